// file: include/rstc_pkg.sv
// shared constants and types of the system reset controller
package rstc_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_SOFT   = 8'h04;
	localparam logic [7:0] OFF_MODULE_ENABLE_BIT  = 8'h08;
	localparam logic [7:0] OFF_CAUSE  = 8'h0C;
	localparam logic [7:0] OFF_STATE  = 8'h10;

	// control register field positions
	localparam int CTRL_KEY_EN_BIT   = 0;
	localparam int CTRL_WDT_MODE_BIT = 1;
	localparam int CTRL_SVD_EN_BIT   = 2;
	localparam int CTRL_KEY_SEL_LSB  = 8;

	// state register field positions
	localparam int STATE_H0_BIT   = 0;
	localparam int STATE_H1_BIT   = 1;
	localparam int STATE_SOFT_LSB = 8;

	// cause register bit positions
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_PWR = 1;
	localparam int CAUSE_KEY = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_SVD = 4;
	localparam int CAUSE_W   = 5;

	// sizes of the peripheral and key pin sets
	localparam int NUM_PERIPH = 8;
	localparam int NUM_KEY    = 4;

	// peripherals whose module enable clear acts as a soft reset
	localparam logic [7:0] MODULE_ENABLE_BIT_RESET_MASK = 8'h0F;

	// reset values
	localparam logic [7:0] MODULE_ENABLE_BIT_RESET = 8'h00;
	localparam logic [3:0] KEY_SEL_RESET = 4'h0;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing: times in ns, counts derived from the clock period
	localparam int CLK_PERIOD_NS  = 10;
	localparam int HOLD_TIME_NS   = 1000;
	localparam int FILTER_TIME_NS = 200;
	localparam int KEY_TIME_NS    = 20000;
	localparam int HOLD_CYCLES    =
		(HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_CYCLES  =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int KEY_CYCLES     =
		(KEY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 12;

	// control fields written by software
	typedef struct packed {
		logic [3:0] key_sel;
		logic       svd_en;
		logic       wdt_mode;
		logic       key_en;
	} rstc_ctrl_t;

	// hard group release sequence, gray coded
	typedef enum logic [1:0] {
		GRP_ASSERT = 2'b00,
		GRP_HOLD   = 2'b01,
		GRP_RUN    = 2'b11
	} rstc_grp_t;

endpackage

// file: core/rstc_in_filter.sv
// synchroniser and width filter for one asynchronous input
`timescale 1ns/1ns
module rstc_in_filter #(
	parameter int         CYCLES    = 1,
	parameter logic       RST_LEVEL = 1'b0
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// raw input and filtered level
	input  wire logic pin,
	output logic      level
);

	logic                       s1;
	logic                       s2;
	logic                       s3;
	logic [rstc_pkg::CNT_W-1:0] cnt;

	localparam logic [rstc_pkg::CNT_W-1:0] LAST =
		rstc_pkg::CNT_W'(CYCLES - 1);

	// three stage synchroniser, s1 feeds only s2
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= RST_LEVEL;
			s2 <= RST_LEVEL;
			s3 <= RST_LEVEL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a new level must stand for CYCLES agreeing samples
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt   <= '0;
			level <= RST_LEVEL;
		end else if (s2 != s3 || s3 == level) begin
			cnt <= '0; // short pulses never reach the output
		end else if (cnt == LAST) begin
			cnt   <= '0;
			level <= s3;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule

// file: core/rstc_top.sv
// system reset controller: source collection, groups and axi registers
`timescale 1ns/1ns
module rstc_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// reset sources from pins and monitors
	input  wire logic        ext_reset_n,
	input  wire logic        por_detect,
	input  wire logic        bor_detect,
	input  wire logic        svd_drop,
	input  wire logic        supply_stable,
	input  wire logic        osc_stable,
	input  wire logic [3:0]  key_pin_n,
	// watchdog overflow pulse, same clock
	input  wire logic        wdt_overflow,
	// reset group outputs
	output logic             hard_group_all_sources_n,
	output logic             hard_group_pin_power_n,
	output logic [7:0]       soft_group_n,
	output logic [7:0]       module_enable_bit,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam logic [rstc_pkg::CNT_W-1:0] HOLD_LAST =
		rstc_pkg::CNT_W'(rstc_pkg::HOLD_CYCLES - 1);

	// word select of a byte address
	function automatic logic hit(input logic [7:0] addr,
			input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	// any of the mapped offsets
	function automatic logic mapped(input logic [7:0] addr);
		mapped = hit(addr, rstc_pkg::OFF_CTRL)
			| hit(addr, rstc_pkg::OFF_SOFT)
			| hit(addr, rstc_pkg::OFF_MODULE_ENABLE_BIT)
			| hit(addr, rstc_pkg::OFF_CAUSE)
			| hit(addr, rstc_pkg::OFF_STATE);
	endfunction

	// filtered source levels
	logic       pin_lvl;
	logic       por_lvl;
	logic       bor_lvl;
	logic       svd_lvl;
	logic       vdd_ok_lvl;
	logic       osc_ok_lvl;
	logic [3:0] key_lvl;

	// software state
	rstc_pkg::rstc_ctrl_t ctrl;
	logic [4:0]           cause;
	logic [7:0]           soft_req;

	// bus state
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic        next_bvalid;
	logic        next_rvalid;
	logic        wr_fire;

	// group sequencing
	rstc_pkg::rstc_grp_t        state [2];
	rstc_pkg::rstc_grp_t        next_state [2];
	logic [rstc_pkg::CNT_W-1:0] hold_cnt [2];
	logic [1:0]                 grp_req;

	// request levels of the sources
	logic pin_req;
	logic pwr_req;
	logic key_req;
	logic wdt_req;
	logic svd_req;
	logic unstable;

	// pin noise filter; idle level is high from the pull-up
	rstc_in_filter #(
		.CYCLES    (rstc_pkg::FILTER_CYCLES),
		.RST_LEVEL (1'b1)
	) u_pin_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (ext_reset_n),
		.level   (pin_lvl)
	);

	// monitors start idle so reset logs no false cause; state holds reset
	rstc_in_filter #(.CYCLES(1), .RST_LEVEL(1'b0)) u_por_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (por_detect),
		.level   (por_lvl)
	);
	rstc_in_filter #(.CYCLES(1), .RST_LEVEL(1'b0)) u_bor_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (bor_detect),
		.level   (bor_lvl)
	);
	rstc_in_filter #(.CYCLES(1), .RST_LEVEL(1'b0)) u_svd_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (svd_drop),
		.level   (svd_lvl)
	);
	rstc_in_filter #(.CYCLES(1), .RST_LEVEL(1'b0)) u_vdd_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (supply_stable),
		.level   (vdd_ok_lvl)
	);
	rstc_in_filter #(.CYCLES(1), .RST_LEVEL(1'b0)) u_osc_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (osc_stable),
		.level   (osc_ok_lvl)
	);

	// key pins must stay low for the key time to count
	for (genvar k = 0; k < rstc_pkg::NUM_KEY; k++) begin : g_key
		rstc_in_filter #(
			.CYCLES    (rstc_pkg::KEY_CYCLES),
			.RST_LEVEL (1'b1)
		) u_key_filt (
			.aclk    (aclk),
			.aresetn (aresetn),
			.pin     (key_pin_n[k]),
			.level   (key_lvl[k])
		);
	end

	// source requests
	assign pin_req  = ~pin_lvl;
	assign pwr_req  = por_lvl | bor_lvl;
	assign key_req  = ctrl.key_en & (|ctrl.key_sel)
		& ((key_lvl & ctrl.key_sel) == 4'h0);
	assign wdt_req  = ctrl.wdt_mode & wdt_overflow;
	assign svd_req  = ctrl.svd_en & svd_lvl;
	assign unstable = ~vdd_ok_lvl | ~osc_ok_lvl;

	// group membership; a one-cycle watchdog pulse is stretched by the hold
	assign grp_req[0] = pin_req | pwr_req | key_req | wdt_req | svd_req
		| unstable;
	assign grp_req[1] = pin_req | pwr_req | unstable;

	// release sequence: any request returns to assert at once
	always_comb begin
		for (int g = 0; g < 2; g++) begin
			next_state[g] = state[g];
			if (grp_req[g]) begin
				next_state[g] = rstc_pkg::GRP_ASSERT;
			end else begin
				unique case (state[g])
					rstc_pkg::GRP_ASSERT: begin
						next_state[g] = rstc_pkg::GRP_HOLD;
					end
					rstc_pkg::GRP_HOLD: begin
						if (hold_cnt[g] == HOLD_LAST) begin
							next_state[g] = rstc_pkg::GRP_RUN;
						end
					end
					rstc_pkg::GRP_RUN: begin
						next_state[g] = rstc_pkg::GRP_RUN;
					end
					default: begin
						next_state[g] = rstc_pkg::GRP_ASSERT;
					end
				endcase
			end
		end
	end

	// group state, hold counters and registered reset outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int g = 0; g < 2; g++) begin
				state[g]    <= rstc_pkg::GRP_ASSERT;
				hold_cnt[g] <= '0;
			end
			hard_group_all_sources_n <= 1'b0;
			hard_group_pin_power_n   <= 1'b0;
		end else begin
			for (int g = 0; g < 2; g++) begin
				state[g] <= next_state[g];
				if (next_state[g] == rstc_pkg::GRP_HOLD) begin
					hold_cnt[g] <= (state[g] == rstc_pkg::GRP_HOLD)
						? hold_cnt[g] + 1'b1 : '0;
				end else begin
					hold_cnt[g] <= '0;
				end
			end
			// release only on a clock edge, never mid-cycle
			hard_group_all_sources_n <=
				(next_state[0] == rstc_pkg::GRP_RUN);
			hard_group_pin_power_n   <=
				(next_state[1] == rstc_pkg::GRP_RUN);
		end
	end

	// write path bookkeeping
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_bvalid  = s_axi_bvalid;
		next_rvalid  = s_axi_rvalid;
		if (s_axi_awvalid & s_axi_awready) begin
			next_aw_held = 1'b1;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			next_w_held = 1'b1;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
		end else if (s_axi_bvalid & s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid & s_axi_arready) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rvalid & s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= rstc_pkg::RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_axi_bvalid  <= next_bvalid;
			// no new beat while a response is still owed
			s_axi_awready <= ~next_aw_held & ~next_bvalid;
			s_axi_wready  <= ~next_w_held & ~next_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bresp <= mapped(aw_addr) ? rstc_pkg::RESP_OKAY
					: rstc_pkg::RESP_SLVERR;
			end
		end
	end

	// control and module enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl              <= '0;
			ctrl.key_sel      <= rstc_pkg::KEY_SEL_RESET;
			module_enable_bit <= rstc_pkg::MODULE_ENABLE_BIT_RESET;
		end else if (wr_fire) begin
			if (hit(aw_addr, rstc_pkg::OFF_CTRL) && w_strb[0]) begin
				ctrl.key_en   <= w_data[rstc_pkg::CTRL_KEY_EN_BIT];
				ctrl.wdt_mode <= w_data[rstc_pkg::CTRL_WDT_MODE_BIT];
				ctrl.svd_en   <= w_data[rstc_pkg::CTRL_SVD_EN_BIT];
			end
			if (hit(aw_addr, rstc_pkg::OFF_CTRL) && w_strb[1]) begin
				ctrl.key_sel <= w_data[rstc_pkg::CTRL_KEY_SEL_LSB +: 4];
			end
			// only module_enable_bit changes; other control state is left alone
			if (hit(aw_addr, rstc_pkg::OFF_MODULE_ENABLE_BIT) && w_strb[0]) begin
				module_enable_bit <= w_data[7:0];
			end
		end
	end

	// soft reset pulses: bit writes plus masked enable clears
	always_comb begin
		soft_req = 8'h00;
		if (wr_fire && w_strb[0]) begin
			if (hit(aw_addr, rstc_pkg::OFF_SOFT)) begin
				soft_req = w_data[7:0];
			end
			if (hit(aw_addr, rstc_pkg::OFF_MODULE_ENABLE_BIT)) begin
				soft_req = module_enable_bit & ~w_data[7:0]
					& rstc_pkg::MODULE_ENABLE_BIT_RESET_MASK;
			end
		end
	end

	// soft group has no hold: low for one cycle, the cycle after the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_group_n <= 8'hFF;
		end else begin
			soft_group_n <= ~soft_req;
		end
	end

	// sticky cause flags; a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause <= 5'h00;
		end else begin
			if (wr_fire && w_strb[0]
					&& hit(aw_addr, rstc_pkg::OFF_CAUSE)) begin
				cause <= (cause & ~w_data[4:0])
					| {svd_req, wdt_req, key_req, pwr_req, pin_req};
			end else begin
				cause <= cause
					| {svd_req, wdt_req, key_req, pwr_req, pin_req};
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= rstc_pkg::RESP_OKAY;
		end else begin
			s_axi_rvalid  <= next_rvalid;
			s_axi_arready <= ~next_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= rstc_pkg::RESP_OKAY;
				if (hit(s_axi_araddr, rstc_pkg::OFF_CTRL)) begin
					s_axi_rdata[rstc_pkg::CTRL_KEY_EN_BIT]   <= ctrl.key_en;
					s_axi_rdata[rstc_pkg::CTRL_WDT_MODE_BIT] <= ctrl.wdt_mode;
					s_axi_rdata[rstc_pkg::CTRL_SVD_EN_BIT]   <= ctrl.svd_en;
					s_axi_rdata[rstc_pkg::CTRL_KEY_SEL_LSB +: 4] <=
						ctrl.key_sel;
				end else if (hit(s_axi_araddr, rstc_pkg::OFF_MODULE_ENABLE_BIT)) begin
					s_axi_rdata[7:0] <= module_enable_bit;
				end else if (hit(s_axi_araddr, rstc_pkg::OFF_CAUSE)) begin
					s_axi_rdata[4:0] <= cause;
				end else if (hit(s_axi_araddr, rstc_pkg::OFF_STATE)) begin
					s_axi_rdata[rstc_pkg::STATE_H0_BIT] <=
						hard_group_all_sources_n;
					s_axi_rdata[rstc_pkg::STATE_H1_BIT] <=
						hard_group_pin_power_n;
					s_axi_rdata[rstc_pkg::STATE_SOFT_LSB +: 8] <=
						~soft_group_n;
				end else if (!hit(s_axi_araddr, rstc_pkg::OFF_SOFT)) begin
					s_axi_rresp <= rstc_pkg::RESP_SLVERR;
				end
			end
		end
	end

endmodule

// file: verif/rstc_props.sv
// port checks of the reset controller, bound to rstc_top
`timescale 1ns/1ns
module rstc_props (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// reset sources
	input  wire logic       ext_reset_n,
	input  wire logic       por_detect,
	input  wire logic       bor_detect,
	input  wire logic       supply_stable,
	input  wire logic       osc_stable,
	// group outputs
	input  wire logic       hard_group_all_sources_n,
	input  wire logic       hard_group_pin_power_n,
	input  wire logic [7:0] soft_group_n,
	input  wire logic [7:0] module_enable_bit
);
	logic [7:0] low_cnt;
	logic [7:0] quiet_cnt;
	logic [7:0] pin_cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles the full group has been held low, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn || hard_group_all_sources_n)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hFF)
			low_cnt <= low_cnt + 8'h01;
	end
	// cycles with no narrow source; the pin is left out since glitches vanish
	always_ff @(posedge aclk) begin
		if (!aresetn || por_detect || bor_detect || !supply_stable || !osc_stable)
			quiet_cnt <= 8'h00;
		else if (quiet_cnt != 8'hFF)
			quiet_cnt <= quiet_cnt + 8'h01;
	end
	// cycles the reset pin has stayed low
	always_ff @(posedge aclk) begin
		if (!aresetn || ext_reset_n)
			pin_cnt <= 8'h00;
		else if (pin_cnt != 8'hFF)
			pin_cnt <= pin_cnt + 8'h01;
	end
	property p_nest;
		!hard_group_pin_power_n |-> !hard_group_all_sources_n;
	endproperty
	a_nest: assert property (p_nest) else $error("narrow group alone");
	property p_hold;
		$rose(hard_group_all_sources_n) |-> low_cnt >= 8'h64;
	endproperty
	a_hold: assert property (p_hold) else $error("full hold short");
	property p_quiet;
		$rose(hard_group_pin_power_n) |-> quiet_cnt >= 8'h64;
	endproperty
	a_quiet: assert property (p_quiet) else $error("narrow early");
	property p_unstable;
		(!supply_stable || !osc_stable) [*6] |-> !hard_group_pin_power_n;
	endproperty
	a_unstable: assert property (p_unstable) else $error("unstable run");
	property p_por;
		por_detect [*6] |-> !hard_group_pin_power_n && !hard_group_all_sources_n;
	endproperty
	a_por: assert property (p_por) else $error("power-on ignored");
	property p_pin;
		pin_cnt >= 8'h1E |-> !hard_group_pin_power_n;
	endproperty
	a_pin: assert property (p_pin) else $error("pin ignored");
	property p_soft;
		soft_group_n != 8'hFF |=> soft_group_n == 8'hFF;
	endproperty
	a_soft: assert property (p_soft) else $error("soft pulse long");
	property p_keep;
		(($past(module_enable_bit) & ~module_enable_bit) & 8'hF0) != 8'h00
			|-> &soft_group_n[7:4];
	endproperty
	a_keep: assert property (p_keep) else $error("enable clear reset");
	property p_mrst;
		$fell(module_enable_bit[0]) |-> !soft_group_n[0];
	endproperty
	a_mrst: assert property (p_mrst) else $error("no enable reset");
endmodule
bind rstc_top rstc_props rstc_props_i (.aclk, .aresetn, .ext_reset_n,
	.por_detect, .bor_detect, .supply_stable, .osc_stable,
	.hard_group_all_sources_n, .hard_group_pin_power_n, .soft_group_n,
	.module_enable_bit);

// file: verif/rstc_partner.sv
// far-side model: reset pin, power monitors, key pins and watchdog
`timescale 1ns/1ns
module rstc_partner (
	// clock
	input  wire logic       aclk,
	// reset sources
	output logic            ext_reset_n,
	output logic            por_detect,
	output logic            bor_detect,
	output logic            svd_drop,
	output logic            supply_stable,
	output logic            osc_stable,
	output logic [3:0]      key_pin_n,
	output logic            wdt_overflow
);
	// quiet: pulled-up pins released, supply and clock good
	task automatic idle();
		ext_reset_n <= 1'b1;
		por_detect <= 1'b0;
		bor_detect <= 1'b0;
		svd_drop <= 1'b0;
		supply_stable <= 1'b1;
		osc_stable <= 1'b1;
		key_pin_n <= 4'hF;
		wdt_overflow <= 1'b0;
	endtask
	initial idle();
	// hold source k active n cycles; a key press holds pins 1:0 low
	task automatic fire(input int k, input int n);
		@(posedge aclk);
		case (k)
			0: ext_reset_n <= 1'b0;
			1: por_detect <= 1'b1;
			2: key_pin_n <= 4'hC;
			3: wdt_overflow <= 1'b1;
			4: svd_drop <= 1'b1;
			5: supply_stable <= 1'b0;
			6: bor_detect <= 1'b1;
			default: osc_stable <= 1'b0;
		endcase
		repeat (n) @(posedge aclk);
		idle();
	endtask
endmodule

// file: verif/tb.sv
// self-checking bench of the system reset controller
`timescale 1ns/1ns
module tb;
	logic        aclk, aresetn, ext_reset_n, por_detect, bor_detect;
	logic        svd_drop, supply_stable, osc_stable, wdt_overflow;
	logic [3:0]  key_pin_n, s_axi_wstrb;
	logic        hard_group_all_sources_n, hard_group_pin_power_n;
	logic [7:0]  soft_group_n, module_enable_bit, soft_and;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, seen_full, seen_narrow;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          n_mismatch = 0;
	int          compares = 0;
	rstc_top rstc_top_i (.aclk, .aresetn, .ext_reset_n, .por_detect,
		.bor_detect, .svd_drop, .supply_stable, .osc_stable, .key_pin_n,
		.wdt_overflow, .hard_group_all_sources_n, .hard_group_pin_power_n,
		.soft_group_n, .module_enable_bit, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	rstc_partner rstc_partner_i (.aclk, .ext_reset_n, .por_detect,
		.bor_detect, .svd_drop, .supply_stable, .osc_stable, .key_pin_n,
		.wdt_overflow);
	// 100 MHz clock
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;
	// sticky record of group resets and soft pulses
	always @(posedge aclk) begin
		if (hard_group_all_sources_n !== 1'b1) seen_full = 1'b1;
		if (hard_group_pin_power_n !== 1'b1) seen_narrow = 1'b1;
		soft_and = soft_and & soft_group_n;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one write; each channel released at its own handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		if (n >= 200) n_mismatch++;
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		if (n >= 200) n_mismatch++;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// bounded wait for both groups; key release is filtered for key time too
	task automatic wait_release();
		int n;
		while ((hard_group_all_sources_n & hard_group_pin_power_n) !== 1'b1
			&& n < rstc_pkg::KEY_CYCLES + 600) begin
			@(posedge aclk);
			n++;
		end
		if (n >= rstc_pkg::KEY_CYCLES + 600) n_mismatch++;
	endtask
	// fire source k with its enables set or clear, model groups and cause
	task automatic src_case(input int k, input int e);
		int n;
		int ec;
		ec = (k == 6) ? 2 : (k < 5 && e != 0) ? (1 << k) : 0;
		axi_wr(rstc_pkg::OFF_CTRL, (e != 0) ? 32'h00000307 : 32'h00000300);
		seen_full = 1'b0;
		seen_narrow = 1'b0;
		n = (k == 2) ? rstc_pkg::KEY_CYCLES + 40 : (k == 3) ? 1 : 10;
		rstc_partner_i.fire(k, (k == 0 && e != 0) ? 40 : n);
		repeat (30) @(posedge aclk);
		wait_release();
		chk(seen_full, e);
		chk(seen_narrow, e != 0 && !(k inside {2, 3, 4}));
		axi_rd(rstc_pkg::OFF_CAUSE);
		chk(rd, ec);
		axi_wr(rstc_pkg::OFF_CAUSE, 32'h0000001F);
		axi_rd(rstc_pkg::OFF_CAUSE);
		chk(rd, 32'h00000000);
	endtask
	// bench sequence
	initial begin
		logic [7:0] r;
		logic [7:0] offs [4];
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
		offs = '{rstc_pkg::OFF_CTRL, rstc_pkg::OFF_SOFT,
			rstc_pkg::OFF_MODULE_ENABLE_BIT, rstc_pkg::OFF_CAUSE};
		void'($urandom(32'h7870D370));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wait_release();
		foreach (offs[i]) begin
			axi_rd(offs[i]);
			chk(rd, 32'h00000000);
		end
		axi_rd(8'h14);
		chk(resp, rstc_pkg::RESP_SLVERR);
		axi_wr(8'h20, 32'h0);
		chk(resp, rstc_pkg::RESP_SLVERR);
		axi_wr(rstc_pkg::OFF_STATE, 32'h0);
		chk(resp, rstc_pkg::RESP_OKAY);
		axi_rd(rstc_pkg::OFF_STATE);
		chk(rd & 32'h3, 32'h3);
		for (int k = 0; k < 8; k++)
			for (int e = 0; e < 2; e++)
				if (e != 0 || k == 0 || k inside {2, 3, 4}) src_case(k, e);
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom_range(255, 1));
			soft_and = 8'hFF;
			axi_wr(rstc_pkg::OFF_SOFT, {24'h0, r});
			repeat (2) @(posedge aclk);
			chk(soft_and, {24'h0, ~r});
		end
		axi_wr(rstc_pkg::OFF_MODULE_ENABLE_BIT, 32'h000000FF);
		chk(module_enable_bit, 32'h000000FF);
		soft_and = 8'hFF;
		axi_wr(rstc_pkg::OFF_MODULE_ENABLE_BIT, 32'h0);
		repeat (2) @(posedge aclk);
		chk(soft_and, {24'h0, ~rstc_pkg::MODULE_ENABLE_BIT_RESET_MASK});
		axi_rd(rstc_pkg::OFF_MODULE_ENABLE_BIT);
		chk(rd, 32'h00000000);
		finish_test();
	end
	// cut a hang short well past the expected run length
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
endmodule
